// ### common/drd_pkg.sv
// Shared constants and carrier types for the director read and dispatch block.
package drd_pkg;

   // ------------------------------------------------------------------
   // Clock and read timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int RT10_NS       = 10;
   localparam int RT100_NS      = 100;
   localparam int RT130_NS      = 130;
   localparam int RT190_NS      = 190;
   localparam int RT230_NS      = 230;
   localparam int RT240_NS      = 240;
   localparam int RT300_NS      = 300;
   localparam int RT10_CYC  = (RT10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT100_CYC = (RT100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT130_CYC = (RT130_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT190_CYC = (RT190_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT230_CYC = (RT230_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT240_CYC = (RT240_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RT300_CYC = (RT300_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W     = 4;
   localparam logic [CNT_W-1:0] RT10_C  = CNT_W'(RT10_CYC);
   localparam logic [CNT_W-1:0] RT100_C = CNT_W'(RT100_CYC);
   localparam logic [CNT_W-1:0] RT130_C = CNT_W'(RT130_CYC);
   localparam logic [CNT_W-1:0] RT190_C = CNT_W'(RT190_CYC);
   localparam logic [CNT_W-1:0] RT230_C = CNT_W'(RT230_CYC);
   localparam logic [CNT_W-1:0] RT240_C = CNT_W'(RT240_CYC);
   localparam logic [CNT_W-1:0] RT300_C = CNT_W'(RT300_CYC);

   // ------------------------------------------------------------------
   // Director buffer and director format
   // ------------------------------------------------------------------
   localparam int PTR_W    = 4;
   localparam int DIR_W    = 32;
   localparam int CLASS_HI = 7;
   localparam int CLASS_LO = 6;
   localparam logic [1:0] CLASS_TERM = 2'h0;
   localparam logic [1:0] CLASS_DATA = 2'h1;
   localparam logic [1:0] CLASS_SUPP = 2'h2;
   localparam logic [1:0] CLASS_ADDR = 2'h3;

   // ------------------------------------------------------------------
   // Host function and register map
   // ------------------------------------------------------------------
   localparam logic [15:0] FN_EXEC_DIRECTORS = 16'h0022;
   localparam logic [7:0]  FN_CHANNEL        = 8'h08;
   localparam int FN_CODE_LO = 0;
   localparam int FN_CH_LO   = 16;
   localparam logic [3:0] REG_FUNC   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_DIROUT = 4'h8;
   localparam logic [3:0] REG_PTRS   = 4'hc;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } drd_avs_req_t;

   typedef struct packed {
      logic active;       // Write timing chain owns the director bus.
      logic t10;          // Write time 10 pulse.
      logic t50;          // Write time 50 pulse.
      logic inc_point;    // Point where the input address may advance.
      logic lower;        // Current write chain carries the lower half.
      logic req_upper;    // Request for the upper word of a director.
      logic req_next;     // Request for the next director.
      logic term_decode;  // Look-ahead decode sees a terminate director.
   } drd_wt_t;

endpackage

// ### logic/drd_core.sv
// Director buffer read timing, terminate loading and director dispatch.
`timescale 1ns/1ps
`default_nettype none

module drd_core
   import drd_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire drd_avs_req_t     avs_req,
   output logic [31:0]           avs_readdata,
   output logic                  avs_waitrequest,
   input  wire drd_wt_t          wt,
   input  wire logic [DIR_W-1:0] dir_bus,
   input  wire logic             support_complete,
   input  wire logic             data_complete,
   output logic                  read_gate_enable,
   output logic                  start_execution_pulse,
   output logic                  write_timing_enable,
   output logic                  buffer_input_increment,
   output logic                  buffer_output_increment,
   output logic                  output_register_strobe,
   output logic                  output_address_hold_strobe,
   output logic                  data_execute_pulse,
   output logic                  support_execute_pulse,
   output logic                  support_clear_pulse,
   output logic                  data_on,
   output logic                  terminate_flag,
   output logic                  decode_enable,
   output logic                  address_director_flag,
   output logic [PTR_W-1:0]      buffer_write_address,
   output logic [PTR_W-1:0]      buffer_read_address,
   output logic [DIR_W-1:0]      director_out
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]      rdata;
      logic             wait_req;
      logic             gate_en;
      logic             start_p;
      logic             start_d;
      logic             wt_en;
      logic             inhibit_w;
      logic             rd_init;
      logic             run;
      logic [CNT_W-1:0] cnt;
      logic             sup_req;
      logic             dat_req;
      logic [PTR_W-1:0] in_ptr;
      logic [PTR_W-1:0] out_ptr;
      logic [PTR_W-1:0] hold_ptr;
      logic             empty;
      logic [DIR_W-1:0] out_reg;
      logic             sup_dec;
      logic             dat_dec;
      logic             addr_dec;
      logic             sup_ready;
      logic             addr_ff;
      logic             sup_ctl;
      logic             dat_ctl;
      logic             sup_wait;
      logic             dat_pend;
      logic             term_ff;
      logic             dec_en;
      logic             in_inc_p;
      logic             out_inc_p;
      logic             sopd_p;
      logic             hold_p;
      logic             dat_exec_p;
      logic             sup_exec_p;
      logic             sup_clr_p;
      logic             dat_on_p;
   } drd_state_t;

   drd_state_t state_ff;
   drd_state_t nxt_state;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic             tick;
      logic             go;
      logic             at10;
      logic             at100;
      logic             at130;
      logic             at190;
      logic             at240;
      logic             at300;
      logic             acc;
      logic             fn_hit;
      logic             in_inc;
      logic             exec_sup;
      logic             exec_dat;
      logic [1:0]       cls;
      logic [31:0]      rd_word;
      tick     = 1'b0;
      go       = 1'b0;
      at10     = 1'b0;
      at100    = 1'b0;
      at130    = 1'b0;
      at190    = 1'b0;
      at240    = 1'b0;
      at300    = 1'b0;
      acc      = 1'b0;
      fn_hit   = 1'b0;
      in_inc   = 1'b0;
      exec_sup = 1'b0;
      exec_dat = 1'b0;
      cls      = dir_bus[CLASS_HI:CLASS_LO];
      rd_word  = RD_UNMAPPED;
      nxt_state = state_ff;

      // Every pulse output lasts exactly one cycle.
      nxt_state.start_p    = 1'b0;
      nxt_state.in_inc_p   = 1'b0;
      nxt_state.out_inc_p  = 1'b0;
      nxt_state.sopd_p     = 1'b0;
      nxt_state.hold_p     = 1'b0;
      nxt_state.dat_exec_p = 1'b0;
      nxt_state.sup_exec_p = 1'b0;
      nxt_state.sup_clr_p  = 1'b0;
      nxt_state.dat_on_p   = 1'b0;
      nxt_state.start_d    = state_ff.start_p;

      // ---------------------------------------------------------------
      // Avalon slave: one wait state, then the answer for one cycle.
      // ---------------------------------------------------------------
      acc = (avs_req.read | avs_req.write) & ~state_ff.wait_req;
      if ((avs_req.read | avs_req.write) & state_ff.wait_req) begin
         nxt_state.wait_req = 1'b0;
      end else begin
         nxt_state.wait_req = 1'b1;
      end
      case (avs_req.address)
         REG_FUNC, REG_STATUS: begin
            rd_word = {17'h0_0000,
                       state_ff.dat_pend, state_ff.sup_wait,
                       state_ff.addr_ff, state_ff.rd_init,
                       state_ff.inhibit_w, state_ff.dat_req,
                       state_ff.sup_req, state_ff.sup_ready,
                       state_ff.dat_ctl, state_ff.sup_ctl,
                       state_ff.dec_en, state_ff.term_ff,
                       state_ff.run, state_ff.empty, state_ff.gate_en};
         end
         REG_DIROUT: begin
            rd_word = state_ff.out_reg;
         end
         REG_PTRS: begin
            rd_word = {20'h0_0000, state_ff.hold_ptr,
                       state_ff.out_ptr, state_ff.in_ptr};
         end
         default: begin
            rd_word = RD_UNMAPPED;
         end
      endcase
      if (avs_req.read & state_ff.wait_req) begin
         nxt_state.rdata = rd_word;
      end
      fn_hit = acc & avs_req.write & (avs_req.address == REG_FUNC)
             & (avs_req.writedata[FN_CODE_LO +: 16] == FN_EXEC_DIRECTORS)
             & (avs_req.writedata[FN_CH_LO +: 8] == FN_CHANNEL);

      // ---------------------------------------------------------------
      // Execute-directors function
      // ---------------------------------------------------------------
      if (fn_hit) begin
         nxt_state.gate_en = 1'b1;
         nxt_state.start_p = 1'b1;
         nxt_state.sup_req = 1'b1;
         nxt_state.sup_ctl = 1'b1;
         nxt_state.dat_ctl = 1'b1;
      end
      if (state_ff.start_d & ~state_ff.empty & ~wt.active) begin
         nxt_state.rd_init = 1'b1;
      end

      // ---------------------------------------------------------------
      // Terminate director loading
      // ---------------------------------------------------------------
      if (wt.t10) begin
         nxt_state.term_ff = 1'b0;
      end
      if (wt.t50 & wt.term_decode & state_ff.dec_en) begin
         nxt_state.term_ff = 1'b1;
      end
      // A set terminate flag freezes decode enable, so the next director's
      // upper half is still decoded after a 16-bit terminate.
      if (~state_ff.term_ff) begin
         if (wt.req_next) begin
            nxt_state.dec_en = 1'b1;
         end else if (wt.req_upper) begin
            nxt_state.dec_en = 1'b0;
         end
      end
      in_inc = wt.inc_point & (wt.lower | state_ff.term_ff);
      nxt_state.in_inc_p = in_inc;
      nxt_state.in_ptr   = state_ff.in_ptr + PTR_W'(in_inc);
      if (in_inc) begin
         nxt_state.empty = 1'b0;
      end

      // ---------------------------------------------------------------
      // Read timing chain
      // ---------------------------------------------------------------
      // Write timing holds the counter; the bus is shared with loading.
      tick = state_ff.run & ~wt.active;
      at10  = tick & (state_ff.cnt == RT10_C);
      at100 = tick & (state_ff.cnt == RT100_C);
      at130 = tick & (state_ff.cnt == RT130_C);
      at190 = tick & (state_ff.cnt == RT190_C);
      at240 = tick & (state_ff.cnt == RT240_C);
      at300 = tick & (state_ff.cnt == RT300_C);
      // A director still waiting for its unit keeps the next one unread,
      // so its decode flags cannot be overwritten.
      go = state_ff.rd_init & state_ff.gate_en
         & (state_ff.sup_req | state_ff.dat_req)
         & ~state_ff.run & ~wt.active & ~state_ff.empty
         & ~state_ff.sup_ready & ~state_ff.dat_pend;
      if (go) begin
         nxt_state.run       = 1'b1;
         nxt_state.cnt       = '0;
         nxt_state.wt_en     = 1'b0;
         nxt_state.inhibit_w = 1'b1;
      end else if (tick) begin
         nxt_state.cnt = state_ff.cnt + CNT_W'(1);
      end
      if (at10) begin
         nxt_state.out_inc_p = 1'b1;
         nxt_state.out_ptr   = state_ff.out_ptr + PTR_W'(1);
         nxt_state.sup_req   = fn_hit;
         nxt_state.dat_req   = 1'b0;
      end
      if (at100) begin
         nxt_state.rd_init   = 1'b0;
         nxt_state.sopd_p    = 1'b1;
         nxt_state.out_reg   = dir_bus;
         nxt_state.inhibit_w = 1'b0;
         nxt_state.wt_en     = 1'b1;
         nxt_state.sup_dec   = (cls == CLASS_SUPP) | (cls == CLASS_ADDR);
         nxt_state.addr_dec  = (cls == CLASS_ADDR);
         nxt_state.dat_dec   = (cls == CLASS_DATA);
         // A function arriving in the same cycle keeps the gate open.
         if ((cls == CLASS_TERM) & ~fn_hit) begin
            nxt_state.gate_en = 1'b0;
         end
      end
      if (at130) begin
         nxt_state.empty    = (nxt_state.in_ptr == state_ff.out_ptr);
         nxt_state.hold_p   = 1'b1;
         nxt_state.hold_ptr = state_ff.out_ptr;
      end
      if (at190) begin
         nxt_state.sup_ready = state_ff.sup_dec;
         if (state_ff.addr_dec) begin
            nxt_state.addr_ff = 1'b1;
         end
      end
      if (at300) begin
         nxt_state.run = 1'b0;
      end

      // ---------------------------------------------------------------
      // Data director dispatch
      // ---------------------------------------------------------------
      exec_dat = state_ff.dat_dec
               & ((at240 & state_ff.dat_ctl)
                 | (state_ff.dat_pend & state_ff.dat_ctl));
      if (at240 & state_ff.dat_dec & ~state_ff.dat_ctl) begin
         nxt_state.dat_pend = 1'b1;
      end
      if (exec_dat) begin
         nxt_state.dat_exec_p = 1'b1;
         nxt_state.dat_on_p   = state_ff.dat_pend;
         nxt_state.dat_pend   = 1'b0;
         nxt_state.dat_dec    = 1'b0;
         nxt_state.dat_ctl    = 1'b0;
         nxt_state.dat_req    = 1'b1;
         nxt_state.rd_init    = 1'b1;
      end
      // Completion is a set and outranks the clear from an execute.
      if (data_complete) begin
         nxt_state.dat_ctl = 1'b1;
      end

      // ---------------------------------------------------------------
      // Support director dispatch
      // ---------------------------------------------------------------
      exec_sup = state_ff.sup_ready & state_ff.sup_ctl
               & (at300 | state_ff.sup_wait);
      if (at300 & state_ff.sup_ready & ~state_ff.sup_ctl) begin
         nxt_state.sup_wait = 1'b1;
      end
      if (exec_sup) begin
         nxt_state.sup_exec_p = 1'b1;
         nxt_state.sup_wait   = 1'b0;
         nxt_state.sup_ctl    = 1'b0;
         nxt_state.sup_ready  = 1'b0;
         nxt_state.sup_req    = 1'b1;
         nxt_state.rd_init    = 1'b1;
      end
      if (support_complete) begin
         nxt_state.sup_ctl = 1'b1;
         if (~state_ff.sup_ready) begin
            nxt_state.sup_clr_p = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff          <= '0;
         state_ff.wait_req <= 1'b1;
         state_ff.wt_en    <= 1'b1;
         state_ff.empty    <= 1'b1;
         state_ff.dec_en   <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign avs_readdata               = state_ff.rdata;
   assign avs_waitrequest            = state_ff.wait_req;
   assign read_gate_enable           = state_ff.gate_en;
   assign start_execution_pulse      = state_ff.start_p;
   assign write_timing_enable        = state_ff.wt_en;
   assign buffer_input_increment     = state_ff.in_inc_p;
   assign buffer_output_increment    = state_ff.out_inc_p;
   assign output_register_strobe     = state_ff.sopd_p;
   assign output_address_hold_strobe = state_ff.hold_p;
   assign data_execute_pulse         = state_ff.dat_exec_p;
   assign support_execute_pulse      = state_ff.sup_exec_p;
   assign support_clear_pulse        = state_ff.sup_clr_p;
   assign data_on                    = state_ff.dat_on_p;
   assign terminate_flag             = state_ff.term_ff;
   assign decode_enable              = state_ff.dec_en;
   assign address_director_flag      = state_ff.addr_ff;
   assign buffer_write_address       = state_ff.in_ptr;
   assign buffer_read_address        = state_ff.hold_ptr;
   assign director_out               = state_ff.out_reg;

endmodule // drd_core

`default_nettype wire

// ### tb/drd_core_checker.sv
// Concurrent checks on the director read and dispatch core ports.
`timescale 1ns/1ps
`default_nettype none
module drd_core_checker
   import drd_pkg::*;
(
   input wire logic             clk,
   input wire logic             reset,
   input wire drd_wt_t          wt,
   input wire logic             terminate_flag,
   input wire logic             decode_enable,
   input wire logic             read_gate_enable,
   input wire logic             start_execution_pulse,
   input wire logic             write_timing_enable,
   input wire logic             buffer_output_increment,
   input wire logic             output_register_strobe,
   input wire logic             output_address_hold_strobe,
   input wire logic             data_execute_pulse,
   input wire logic             support_execute_pulse,
   input wire logic             data_on,
   input wire logic [DIR_W-1:0] director_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // -----------------------------------------------------------------
   // Timing chain
   // -----------------------------------------------------------------
   property p_term_set;
      wt.t50 && wt.term_decode && decode_enable && !wt.t10
         |=> terminate_flag;
   endproperty
   a_term_set: assert property (p_term_set)
      else $error("flag not set");
   property p_term_clr;
      wt.t10 && !wt.t50 |=> !terminate_flag;
   endproperty
   a_term_clr: assert property (p_term_clr)
      else $error("flag kept");
   property p_keep_de;
      terminate_flag && decode_enable && wt.req_upper |=> decode_enable;
   endproperty
   a_keep_de: assert property (p_keep_de)
      else $error("decode lost");
   property p_start;
      start_execution_pulse |-> read_gate_enable;
   endproperty
   a_start: assert property (p_start)
      else $error("gate off");
   property p_wte;
      buffer_output_increment |-> !write_timing_enable;
   endproperty
   a_wte: assert property (p_wte)
      else $error("write timing on");
   // A pause of the chain by write timing voids these fixed spacings.
   property p_strobe;
      buffer_output_increment ##0 (!wt.active)[*5] |-> output_register_strobe;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("no strobe");
   property p_hold;
      output_register_strobe ##0 (!wt.active)[*3]
         |-> output_address_hold_strobe;
   endproperty
   a_hold: assert property (p_hold)
      else $error("no hold strobe");
   property p_dde;
      data_execute_pulse && !data_on |-> $past(output_register_strobe, 7)
         && director_out[CLASS_HI:CLASS_LO] == CLASS_DATA;
   endproperty
   a_dde: assert property (p_dde)
      else $error("data exec off time");
   property p_sup;
      support_execute_pulse |-> director_out[CLASS_HI];
   endproperty
   a_sup: assert property (p_sup)
      else $error("support exec wrong");
   c_wait: cover property (data_execute_pulse && data_on);
   c_sup: cover property (support_execute_pulse);
   c_term: cover property (terminate_flag);
endmodule // drd_core_checker
bind drd_core drd_core_checker chk_u (.clk(clk), .reset(reset), .wt(wt),
   .terminate_flag(terminate_flag), .decode_enable(decode_enable),
   .read_gate_enable(read_gate_enable), .data_on(data_on),
   .start_execution_pulse(start_execution_pulse),
   .write_timing_enable(write_timing_enable),
   .buffer_output_increment(buffer_output_increment),
   .output_register_strobe(output_register_strobe),
   .output_address_hold_strobe(output_address_hold_strobe),
   .data_execute_pulse(data_execute_pulse),
   .support_execute_pulse(support_execute_pulse),
   .director_out(director_out));
`default_nettype wire

// ### tb/drd_core_tb.sv
// Self-checking bench for the director read and dispatch core.
`timescale 1ns/1ps
`default_nettype none
module drd_core_tb import drd_pkg::*; ;
   typedef struct {logic [31:0] d; int nd; int ns; logic af;} drd_row_t;
   localparam logic [31:0] EXEC = {8'h00, FN_CHANNEL, FN_EXEC_DIRECTORS};
   logic clk, reset, support_complete, data_complete, mw, af_o, gate;
   logic ws, wte, bii, boi, ors, ohs, dde, sxe, scp, data_on, term, de;
   drd_avs_req_t req;
   drd_wt_t wt;
   logic [31:0] rdata, director_out, dir_bus, md, q;
   logic [3:0] wr_a, rd_a, ma, a;
   logic waitreq;
   int num_errors, check_count, nd, ns, sc, don, sst, i, n;
   drd_row_t rows[3] = '{'{32'h41, 1, 0, 1'b0}, '{32'h82, 0, 1, 1'b0},
                         '{32'hc3, 0, 1, 1'b1}};
   drd_core dut_u (.clk(clk), .reset(reset), .avs_req(req),
      .avs_readdata(rdata), .avs_waitrequest(waitreq), .wt(wt),
      .dir_bus(dir_bus), .support_complete(support_complete),
      .data_complete(data_complete), .read_gate_enable(gate),
      .start_execution_pulse(ws), .write_timing_enable(wte),
      .buffer_input_increment(bii), .buffer_output_increment(boi),
      .output_register_strobe(ors), .output_address_hold_strobe(ohs),
      .data_execute_pulse(dde), .support_execute_pulse(sxe),
      .support_clear_pulse(scp), .data_on(data_on),
      .terminate_flag(term), .decode_enable(de),
      .address_director_flag(af_o), .buffer_write_address(wr_a),
      .buffer_read_address(rd_a), .director_out(director_out));
   drd_dir_mem mem_u (.clk(clk), .we(mw), .wa(ma), .wd(md), .ra(rd_a),
      .rd(dir_bus));
   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   task automatic chk(input logic [31:0] g, e, input string m);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // The master holds the request until it sees waitrequest low.
   // Waitrequest and read data are taken at the edge, before it updates them.
   task automatic bus(input logic w, input logic [3:0] ad,
                      input logic [31:0] d);
      @(posedge clk);
      req <= '{read: !w, write: w, address: ad, writedata: d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdata;
      req <= '0;
      if (n >= 20) begin
         num_errors++;
         finish_test;
      end
   endtask
   task automatic wtp(input logic [7:0] v);
      @(posedge clk);
      wt <= drd_wt_t'(v);
      @(posedge clk);
      wt <= '0;
      #1;
   endtask
   task automatic ld(input logic [31:0] d, input logic [7:0] v);
      @(posedge clk);
      mw <= 1'b1;
      ma <= wr_a;
      md <= d;
      wtp(v);
      mw <= 1'b0;
   endtask
   task automatic watch(input int c);
      {nd, ns, sc, don, sst} = '0;
      repeat (c) begin
         @(posedge clk);
         nd += int'(dde === 1'b1);
         ns += int'(sxe === 1'b1);
         sc += int'(scp === 1'b1);
         don += int'(data_on === 1'b1);
         sst += int'(ws === 1'b1);
         support_complete <= 1'b0;
         data_complete <= 1'b0;
      end
   endtask
   task automatic cpl(input logic s, d);
      @(posedge clk);
      support_complete <= s;
      data_complete <= d;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      {reset, support_complete, data_complete, mw, ma, md} = '1;
      {support_complete, data_complete, mw, ma, md} = '0;
      req = '0;
      wt = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk({wte, de, term, waitreq}, 4'hd, "reset state");
      bus(0, 4'h2, 32'h0);
      chk(q, RD_UNMAPPED, "unmapped read");
      bus(1, REG_FUNC, {8'h00, 8'h09, FN_EXEC_DIRECTORS});
      watch(6);
      chk(32'(sst), 32'h0, "wrong channel");
      $display("test reset and refusal done");
      for (i = 0; i < 3; i++) begin
         ld(rows[i].d, 8'h18);
         bus(1, REG_FUNC, EXEC);
         watch(40);
         chk(32'(sst), 32'h1, "start pulse");
         chk(director_out, rows[i].d, "director");
         chk(32'(nd), 32'(rows[i].nd), "data exec");
         chk(32'(ns), 32'(rows[i].ns), "support exec");
         chk(af_o, rows[i].af, "address flag");
         bus(0, REG_DIROUT, 32'h0);
         chk(q, rows[i].d, "director read back");
         cpl(rows[i].ns == 1, rows[i].nd == 1);
         watch(6);
         chk(32'(sc), 32'(rows[i].ns), "clear pulse");
      end
      $display("test director rows done");
      ld(32'h41, 8'h18);
      ld(32'h45, 8'h18);
      bus(1, REG_FUNC, EXEC);
      watch(60);
      chk(32'(nd), 32'h1, "second data waits");
      cpl(1'b0, 1'b1);
      watch(20);
      chk({31'h0, nd == 1 && don == 1}, 32'h1, "waiting data exec");
      chk(director_out, 32'h45, "read continues");
      cpl(1'b0, 1'b1);
      watch(4);
      $display("test back to back data done");
      wtp(8'h21);
      chk(term, 1'b1, "terminate set");
      wtp(8'h04);
      chk(de, 1'b1, "decode kept");
      a = wr_a;
      // A read is still pending, so the terminate is read as soon as loaded.
      ld(32'h0, 8'h10);
      chk(wr_a, a + 4'h1, "input advance");
      chk(bii, 1'b1, "input increment pulse");
      wtp(8'h40);
      chk(term, 1'b0, "terminate clear");
      ld(32'h41, 8'h18);
      watch(40);
      chk({gate, 31'(nd)}, 32'h0, "dispatch stopped");
      bus(1, REG_FUNC, EXEC);
      repeat (2) @(posedge clk);
      wtp(8'h80);
      watch(40);
      chk(32'(nd), 32'h1, "dispatch resumed");
      chk(director_out, 32'h41, "paused read");
      $display("test terminate done");
      finish_test;
   end
endmodule // drd_core_tb
`default_nettype wire

// ### tb/drd_dir_mem.sv
// Director buffer model standing in for the memory scanner side.
`timescale 1ns/1ps
`default_nettype none
module drd_dir_mem
   import drd_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             we,
   input  wire logic [PTR_W-1:0] wa,
   input  wire logic [DIR_W-1:0] wd,
   input  wire logic [PTR_W-1:0] ra,
   output logic [DIR_W-1:0]      rd
);
   // Entries that were never loaded read unknown, which exposes reads
   // past the input pointer.
   logic [DIR_W-1:0] mem_ff [16];
   always_ff @(posedge clk) begin
      if (we) begin
         mem_ff[wa] <= wd;
      end
   end
   assign rd = mem_ff[ra];
endmodule // drd_dir_mem
`default_nettype wire
